// ---- src/uoes_top.sv ----
/*
 * OUT endpoint status, configuration and byte-count logic, reached by APB.
 * Holds the packet-ready, full, overrun and data error flags, the
 * buffering and isochronous enables, and the received byte count of
 * the head packet, with a second count slot for double buffering.
 * Assumes the serial engine reports each finished packet as a one-cycle
 * pulse on clk_sys and that the FIFO data path lives elsewhere.
 * Assumes one OUT endpoint; endpoint selection is done outside.
 */
// Register access over APB is this design's own decision.
`timescale 1ns/1ps

// Contract
// - FIFO full is 1 at two packets double-buffered, one otherwise.
// - Packet-ready is set once a whole packet is ready for firmware.
// - Control-high bit 7 enables two-packet buffering.
// - Control-high bit 6 selects isochronous (1) or bulk/interrupt (0).
// - Control-high bits 5..0 read zero and ignore writes.
// - Count-low returns the low eight bits of the head (oldest unread) packet's count.
// - Only a firmware write clears overrun; hardware never does.
// - Count-high holds the upper two count bits, other bits zero.
// - A flush drops the next unread packet and clears packet-ready if no other packet is held.
// - The data error flag is meaningful only in isochronous mode.
module uoes_top
    import uoes_pkg::*;
(
    input  wire logic        clk_sys,   // 125 MHz clock
    input  wire logic        rst,       // Sync reset, active high
    input  wire logic        psel,      // APB select
    input  wire logic        penable,   // APB access phase
    input  wire logic        pwrite,    // APB direction
    input  wire logic [11:0] paddr,     // APB byte address
    input  wire logic [31:0] pwdata,    // APB write data
    output logic      [31:0] prdata,    // APB read data
    output logic             pready,    // APB ready
    output logic             pslverr,   // APB error
    input  wire uoes_pkt_t   pkt_in,    // Packet arrival event
    output logic             pkt_accept,// Packet stored, not dropped
    output logic             iso_mode,  // Endpoint in isochronous mode
    output logic             irq        // Level interrupt
);

    // =======================================================
    // State
    logic [1:0] held_r, held_nxt;           // Packets in FIFO
    logic       dbuf_r, iso_r;
    logic       ovr_r, derr_r;
    logic [9:0] cnt_r, cnt2_r;              // Head and queued counts
    logic       derr2_r;
    logic [1:0] ist_r, imask_r;
    logic [31:0] prdata_r;

    // =======================================================
    // Bus decode
    // Upper index bits must be zero, so no register has an alias
    function automatic logic idx_match(input logic [9:0] a,
                                       input logic [7:0] i);
        return a == {2'b00, i};
    endfunction

    wire        acc      = psel && penable;
    wire        wr       = acc && pwrite;
    wire [9:0]  idx      = paddr[11:2];
    wire        hit_cl   = idx_match(idx, UOES_IDX_CTRL_LOW);
    wire        hit_ch   = idx_match(idx, UOES_IDX_CTRL_HIGH);
    wire        hit_nl   = idx_match(idx, UOES_IDX_CNT_LOW);
    wire        hit_nh   = idx_match(idx, UOES_IDX_CNT_HIGH);
    wire        hit_is   = idx_match(idx, UOES_IDX_IRQ_STAT);
    wire        hit_im   = idx_match(idx, UOES_IDX_IRQ_MASK);
    wire        mapped   = hit_cl | hit_ch | hit_nl | hit_nh
                           | hit_is | hit_im;

    // Firmware actions on control-low. Writing zero to packet-ready or
    // one to flush pops the head packet; writing zero to overrun clears
    // it. A write of 0x05 therefore changes nothing, and both pops in
    // one write still pop a single packet.
    wire        wr_cl    = wr && hit_cl;
    wire        clr_rdy  = wr_cl && !pwdata[UOES_BIT_PKT_RDY]
                           && held_r != 2'd0;
    wire        flush    = wr_cl && pwdata[UOES_BIT_FLUSH]
                           && held_r != 2'd0;
    wire        pop      = clr_rdy || flush;
    wire        clr_ovr  = wr_cl && !pwdata[UOES_BIT_OVERRUN];

    // Fullness against the buffer mode
    wire        full     = dbuf_r ? (held_r == 2'd2)
                                  : (held_r != 2'd0);
    wire        rdy      = held_r != 2'd0;
    wire        drop     = pkt_in.valid && full;
    wire        take     = pkt_in.valid && !full;
    // Only a dropped packet raises overrun; a pop never does
    wire        ovr_set  = drop;

    // Read mux
    wire [7:0]  cl_val   = {4'h0, derr_r && iso_r, ovr_r, full, rdy};
    wire [7:0]  ch_val   = {dbuf_r, iso_r, 6'h00};
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = UOES_RD_UNMAPPED;
        if (hit_cl) rd_mux = {24'h0, cl_val};
        if (hit_ch) rd_mux = {24'h0, ch_val};
        if (hit_nl) rd_mux = {24'h0, cnt_r[7:0]};
        if (hit_nh) rd_mux = {30'h0, cnt_r[9:8]};
        if (hit_is) rd_mux = {30'h0, ist_r};
        if (hit_im) rd_mux = {30'h0, imask_r};
    end

    // Occupancy next value; a take and a pop in one cycle cancel out,
    // which only happens double-buffered with one packet held
    always_comb
    begin
        held_nxt = held_r;
        if (take && !pop) held_nxt = held_r + 2'd1;
        if (!take && pop) held_nxt = held_r - 2'd1;
    end

    // Zero wait states: pready is tied high; an unmapped index answers
    // with pslverr, reads zero, and its writes are ignored
    assign pready     = 1'b1;
    assign pslverr    = acc && !mapped;
    assign prdata     = prdata_r;
    assign pkt_accept = take;
    assign iso_mode   = iso_r;
    assign irq        = |(ist_r & imask_r);

    // =======================================================
    // Configuration, occupancy and counts
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            dbuf_r  <= UOES_RST_CTRL_HIGH[UOES_BIT_DBUF];
            iso_r   <= UOES_RST_CTRL_HIGH[UOES_BIT_ISO];
            held_r  <= 2'd0;
            cnt_r   <= UOES_RST_COUNT;
            cnt2_r  <= UOES_RST_COUNT;
            derr_r  <= 1'b0;
            derr2_r <= 1'b0;
        end
        else
        begin
            if (wr && hit_ch)
            begin
                dbuf_r <= pwdata[UOES_BIT_DBUF];
                iso_r  <= pwdata[UOES_BIT_ISO];
            end
            held_r <= held_nxt;
            // Head slot shows the oldest unread packet
            if (take && (held_r == 2'd0 || (pop && held_r == 2'd1)))
            begin
                cnt_r  <= pkt_in.count;
                derr_r <= pkt_in.crc_err;
            end
            else if (pop && held_r == 2'd2)
            begin
                cnt_r  <= cnt2_r;
                derr_r <= derr2_r;
            end
            if (take && (held_r == 2'd1 && !pop || held_r == 2'd2))
            begin
                cnt2_r  <= pkt_in.count;
                derr2_r <= pkt_in.crc_err;
            end
        end
    end

    // Occupancy, fullness, head count and configuration checks; the
    // count check needs an empty FIFO so that the packet lands in the head slot
    AST_FULL_SINGLE: assert property (
        @(posedge clk_sys) disable iff (rst)
        !dbuf_r && held_r == 2'd1 |-> full)
        else $error("full not set with one packet single-buffered");

    AST_FULL_DOUBLE: assert property (
        @(posedge clk_sys) disable iff (rst)
        dbuf_r && held_r == 2'd1 |-> !full)
        else $error("full set with one packet double-buffered");

    AST_HELD_RANGE: assert property (
        @(posedge clk_sys) disable iff (rst)
        held_r != 2'd3)
        else $error("occupancy beyond two packets");

    AST_RDY_SET: assert property (
        @(posedge clk_sys) disable iff (rst)
        take |=> rdy)
        else $error("packet-ready missing after accepted packet");

    AST_FLUSH: assert property (
        @(posedge clk_sys) disable iff (rst)
        flush && held_r == 2'd1 && !take |=> !rdy)
        else $error("flush left packet-ready set");

    AST_CNT: assert property (
        @(posedge clk_sys) disable iff (rst)
        take && held_r == 2'd0 |=> cnt_r == $past(pkt_in.count))
        else $error("count not captured");

    AST_CFG: assert property (
        @(posedge clk_sys) disable iff (rst)
        wr && hit_ch |=> dbuf_r == $past(pwdata[7])
                         && iso_r == $past(pwdata[6]))
        else $error("configuration write lost");

    AST_CFG_KEEP: assert property (
        @(posedge clk_sys) disable iff (rst)
        !(wr && hit_ch) |=> $stable(dbuf_r)
                            && $stable(iso_r))
        else $error("configuration changed without a write");

    // Overrun is sticky; a drop in the clearing cycle wins
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            ovr_r <= 1'b0;
        else if (ovr_set)
            ovr_r <= 1'b1;
        else if (clr_ovr)
            ovr_r <= 1'b0;
    end

    // Overrun checks: a drop always sets the flag and is never accepted,
    // and nothing but a firmware write takes the flag down
    AST_DROP_OVR: assert property (
        @(posedge clk_sys) disable iff (rst)
        drop |=> ovr_r)
        else $error("dropped packet did not set overrun");

    AST_NO_ACCEPT_FULL: assert property (
        @(posedge clk_sys) disable iff (rst)
        pkt_in.valid && full |-> !pkt_accept)
        else $error("packet accepted into a full FIFO");

    AST_OVR_STICKY: assert property (
        @(posedge clk_sys) disable iff (rst)
        ovr_r && !clr_ovr |=> ovr_r)
        else $error("overrun cleared without a write");

    // Interrupt status: write one to clear, set wins
    // Bit 0 marks an accepted packet, bit 1 a dropped one
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ist_r   <= UOES_RST_IRQ;
            imask_r <= UOES_RST_IRQ;
        end
        else
        begin
            ist_r <= (ist_r & ~((wr && hit_is) ? pwdata[1:0] : 2'b00))
                     | {drop, take};
            if (wr && hit_im)
                imask_r <= pwdata[1:0];
        end
    end

    // Read data snapshot at the setup edge; it stands through the access
    // phase, so the master takes it at the edge where pready is high.
    // A packet landing in the setup cycle shows on the next read only.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            prdata_r <= UOES_RD_UNMAPPED;
        else if (psel && !penable)
            prdata_r <= rd_mux;
    end

    // =======================================================
    // Read path checks: prdata is the setup-cycle snapshot, so each
    // prdata expectation uses the state one cycle back
    AST_CH_ZERO: assert property (
        @(posedge clk_sys) disable iff (rst)
        ch_val[5:0] == 6'h00)
        else $error("control-high low bits not zero");

    AST_NL: assert property (
        @(posedge clk_sys) disable iff (rst)
        acc && hit_nl |-> prdata == {24'h0, $past(cnt_r[7:0])})
        else $error("count-low read wrong");

    AST_NH: assert property (
        @(posedge clk_sys) disable iff (rst)
        acc && hit_nh |-> prdata == {30'h0, $past(cnt_r[9:8])})
        else $error("count-high read wrong");

    AST_DERR_GATE: assert property (
        @(posedge clk_sys) disable iff (rst)
        acc && hit_cl && !$past(iso_r) |-> !prdata[UOES_BIT_DATA_ERR])
        else $error("data error shown outside isochronous mode");

    // Main scenarios: loss, two packets held, flush, isochronous error
    COV_DROP:  cover property (@(posedge clk_sys) disable iff (rst) drop);
    COV_DBL:   cover property (@(posedge clk_sys) disable iff (rst)
        dbuf_r && held_r == 2'd2);
    COV_FLUSH: cover property (@(posedge clk_sys) disable iff (rst) flush);
    COV_ISO_ERR: cover property (@(posedge clk_sys) disable iff (rst)
        iso_r && derr_r && held_r != 2'd0);

endmodule

// ---- pkg/uoes_pkg.sv ----
/*
 * Package for the OUT endpoint status block: register indices, field
 * positions, reset values and the packet-event carrier.
 * Assumes a 32-bit APB register bus with one register per aligned word.
 */
package uoes_pkg;

    // =======================================================
    // Register indices (byte address is four times the index)
    localparam logic [7:0] UOES_IDX_CTRL_LOW  = 8'h14;
    localparam logic [7:0] UOES_IDX_CTRL_HIGH = 8'h15;
    localparam logic [7:0] UOES_IDX_CNT_LOW   = 8'h16;
    localparam logic [7:0] UOES_IDX_CNT_HIGH  = 8'h17;
    localparam logic [7:0] UOES_IDX_IRQ_STAT  = 8'h20;
    localparam logic [7:0] UOES_IDX_IRQ_MASK  = 8'h21;

    // =======================================================
    // Field positions
    localparam int UOES_BIT_PKT_RDY  = 0;
    localparam int UOES_BIT_FULL     = 1;
    localparam int UOES_BIT_OVERRUN  = 2;
    localparam int UOES_BIT_DATA_ERR = 3;
    localparam int UOES_BIT_FLUSH    = 4;
    localparam int UOES_BIT_ISO      = 6;
    localparam int UOES_BIT_DBUF     = 7;
    localparam int UOES_CNT_W        = 10;

    // Interrupt status bits
    localparam int UOES_IRQ_PKT      = 0;
    localparam int UOES_IRQ_OVR      = 1;

    // =======================================================
    // Reset values
    localparam logic [7:0]  UOES_RST_CTRL_HIGH = 8'h00;
    localparam logic [9:0]  UOES_RST_COUNT     = 10'h000;
    localparam logic [1:0]  UOES_RST_IRQ       = 2'h0;
    localparam logic [31:0] UOES_RD_UNMAPPED   = 32'h0000_0000;

    // Packet arrival from the serial engine
    typedef struct packed {
        logic       valid;     // One-cycle end of received packet
        logic [9:0] count;     // Bytes in the packet
        logic       crc_err;   // CRC or bit-stuffing fault
    } uoes_pkt_t;

endpackage

// ---- dv/uoes_host_model.sv ----
/* Host side model: sends OUT packet events into the endpoint logic.
   Assumes the bench calls send right after a rising clk_sys edge. */
`timescale 1ns/1ps
module uoes_host_model
    import uoes_pkg::*;
(
    input  wire logic clk_sys,    // Block clock
    input  wire logic pkt_accept, // Packet stored
    output uoes_pkt_t pkt_in      // Packet event
);
    // Idle fields are inverted so a stale count can never pass
    initial pkt_in = '{1'b0, 10'h155, 1'b0};

    // One-cycle packet pulse, accept taken at the same edge
    task automatic send(input logic [9:0] c, input logic e, output logic a);
        pkt_in <= '{1'b1, c, e};
        @(posedge clk_sys);
        a = pkt_accept;
        pkt_in <= '{1'b0, ~c, ~e};
    endtask
endmodule

// ---- dv/usb_out_endpoint_status_test.sv ----
/* Self-checking bench for the OUT endpoint status block.
   Assumes an APB slave that may insert waits and whose read data
   stands at the edge where pready is sampled high. */
`timescale 1ns/1ps
module usb_out_endpoint_status_test
    import uoes_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        rst     = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    uoes_pkt_t   pkt_in;
    logic        pkt_accept;
    logic        iso_mode;
    logic        irq;
    logic        err_seen;
    logic        acc;
    logic [31:0] q;
    int          n_errors  = 0;
    int          cmp_count = 0;

    // 125 MHz clock
    always #4 clk_sys = ~clk_sys;

    uoes_top u_uoes_top (.clk_sys(clk_sys), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pkt_in(pkt_in), .pkt_accept(pkt_accept), .iso_mode(iso_mode),
        .irq(irq));
    uoes_host_model u_uoes_host_model (.clk_sys(clk_sys),
        .pkt_accept(pkt_accept), .pkt_in(pkt_in));

    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Request held until pready is seen high; answer taken at that edge,
    // then one idle cycle so back-to-back calls never clash
    task automatic apb(input logic        w,
                       input logic [7:0]  i,
                       input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {2'b00, i, 2'b00};
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        err_seen = pslverr;
        q        = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [7:0] i, input logic [31:0] exp);
        apb(1'b0, i, 32'h0000_0000);
        chk(q, exp);
    endtask

    task automatic wrap_up();
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        rd(UOES_IDX_CTRL_HIGH, 32'h0000_0000);
        rd(UOES_IDX_CTRL_LOW, 32'h0000_0000);
        apb(1'b1, UOES_IDX_CTRL_HIGH, 32'hffff_ffff);
        chk({31'h0, err_seen}, 32'h0);
        rd(UOES_IDX_CTRL_HIGH, 32'h0000_00c0);
        chk({31'h0, iso_mode}, 32'h1);
        apb(1'b1, UOES_IDX_CTRL_HIGH, 32'h0000_0000);
    endtask

    // Single buffer: one packet fills it, the next is lost
    task automatic t_single();
        u_uoes_host_model.send(10'h2a5, 1'b0, acc);
        chk({31'h0, acc}, 32'h1);
        rd(UOES_IDX_CTRL_LOW, 32'h0000_0003);
        chk({31'h0, irq}, 32'h0);
        rd(UOES_IDX_CNT_LOW, 32'h0000_00a5);
        rd(UOES_IDX_CNT_HIGH, 32'h0000_0002);
        u_uoes_host_model.send(10'h011, 1'b0, acc);
        chk({31'h0, acc}, 32'h0);
        rd(UOES_IDX_CTRL_LOW, 32'h0000_0007);
        apb(1'b1, UOES_IDX_IRQ_MASK, 32'h0000_0003);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, UOES_IDX_CTRL_LOW, 32'h0000_0004);
        rd(UOES_IDX_CTRL_LOW, 32'h0000_0004);
        apb(1'b1, UOES_IDX_CTRL_LOW, 32'h0000_0001);
        rd(UOES_IDX_CTRL_LOW, 32'h0000_0000);
        apb(1'b1, UOES_IDX_IRQ_STAT, 32'h0000_0003);
        chk({31'h0, irq}, 32'h0);
    endtask

    // Double buffer: full at two, flush drops the older packet
    task automatic t_double();
        apb(1'b1, UOES_IDX_CTRL_HIGH, 32'h0000_0080);
        u_uoes_host_model.send(10'h011, 1'b0, acc);
        rd(UOES_IDX_CTRL_LOW, 32'h0000_0001);
        u_uoes_host_model.send(10'h3ff, 1'b0, acc);
        chk({31'h0, acc}, 32'h1);
        rd(UOES_IDX_CTRL_LOW, 32'h0000_0003);
        apb(1'b1, UOES_IDX_CTRL_LOW, 32'h0000_0015);
        rd(UOES_IDX_CTRL_LOW, 32'h0000_0001);
        rd(UOES_IDX_CNT_LOW, 32'h0000_00ff);
        rd(UOES_IDX_CNT_HIGH, 32'h0000_0003);
        apb(1'b1, UOES_IDX_CTRL_LOW, 32'h0000_0004);
        rd(UOES_IDX_CTRL_LOW, 32'h0000_0000);
    endtask

    // Data error only shows in isochronous mode
    task automatic t_iso();
        apb(1'b1, UOES_IDX_IRQ_STAT, 32'h0000_0003);
        apb(1'b1, UOES_IDX_CTRL_HIGH, 32'h0000_0000);
        u_uoes_host_model.send(10'h040, 1'b1, acc);
        rd(UOES_IDX_CTRL_LOW, 32'h0000_0003);
        apb(1'b1, UOES_IDX_CTRL_HIGH, 32'h0000_0040);
        rd(UOES_IDX_CTRL_LOW, 32'h0000_000b);
        rd(UOES_IDX_IRQ_STAT, 32'h0000_0001);
        apb(1'b1, UOES_IDX_CTRL_LOW, 32'h0000_0004);
        apb(1'b1, UOES_IDX_IRQ_STAT, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0);
    endtask

    task automatic t_bad();
        apb(1'b1, 8'h3f, 32'hffff_ffff);
        chk({31'h0, err_seen}, 32'h1);
        rd(8'h3f, 32'h0000_0000);
    endtask

    // Main sequence after a six-cycle reset
    initial
    begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        t_reset();
        t_single();
        t_double();
        t_iso();
        t_bad();
        wrap_up();
    end

    // Watchdog, far beyond the roughly 115 cycles the run needs
    initial
    begin
        #40000;
        n_errors++;
        wrap_up();
    end
endmodule
